// ==== cell_result_pkg.sv ====
// Purpose: shared constants for the cell-voltage result register bank
// Assumes: 8-bit register address, 16-bit register data, channels 3 to 7 held here
// Notes:   channel index 0 stands for cell input 3, index 4 for cell input 7
package cell_result_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_CH = 5;
  localparam int CH_IDX_W = 3;

  // result field: 14-bit code, left-justified in bits 15:2
  localparam int CODE_W = 14;
  localparam int CODE_LSB = 2;
  localparam logic [CODE_LSB-1:0] UNUSED_LOW_BITS = 2'h0;

  // result register offsets, channel 3 first
  localparam logic [ADDR_W-1:0] CH3_OFFSET = 8'h49;
  localparam logic [ADDR_W-1:0] CH4_OFFSET = 8'h4A;
  localparam logic [ADDR_W-1:0] CH5_OFFSET = 8'h4B;
  localparam logic [ADDR_W-1:0] CH6_OFFSET = 8'h4C;
  localparam logic [ADDR_W-1:0] CH7_OFFSET = 8'h4D;
  localparam logic [ADDR_W-1:0] RESULT_OFFSET [NUM_CH] =
    '{CH3_OFFSET, CH4_OFFSET, CH5_OFFSET, CH6_OFFSET, CH7_OFFSET};

  // scan control register: per-channel measure enables and readback select
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h5C;
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_SEL_BIT = 8;

  // reset values
  localparam logic [DATA_W-1:0] RESULT_RESET = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_RESET = 14'h0000;
  localparam logic [NUM_CH-1:0] ENABLE_RESET = 5'h00;
  localparam logic SELECT_RESET = 1'b0;

  // transfer scale: full-scale code equals a 5 V differential input
  localparam int FULL_SCALE_MV = 5000;
  localparam logic [CODE_W-1:0] FULL_SCALE_CODE = 14'h3FFF;

endpackage

// ==== result_store_if.sv ====
// Purpose: carrier between the register bank and one channel result store
// Assumes: one instance per channel, all on the bank clock
// Notes:   code_out is the readback view chosen by filt_sel
`timescale 1ns/10ps
`default_nettype none
interface result_store_if #(
  parameter int CODE_W = cell_result_pkg::CODE_W
);
  logic              sample_load;
  logic              sample_skipped;
  logic              measure_en;
  logic [CODE_W-1:0] avg_code;
  logic [CODE_W-1:0] iir_code;
  logic              filt_sel;
  logic [CODE_W-1:0] code_out;

  modport store (
    input  sample_load,
    input  sample_skipped,
    input  measure_en,
    input  avg_code,
    input  iir_code,
    input  filt_sel,
    output code_out
  );

  modport bank (
    output sample_load,
    output sample_skipped,
    output measure_en,
    output avg_code,
    output iir_code,
    output filt_sel,
    input  code_out
  );
endinterface
`default_nettype wire

// ==== chan_result_store.sv ====
// Purpose: holds the averaged and filtered result of one cell channel
// Assumes: sample fields come from logic on the same clock
// Notes:   both paths are kept so that the readback select can flip at any time
`timescale 1ns/10ps
`default_nettype none
module chan_result_store #(
  parameter int CODE_W = cell_result_pkg::CODE_W
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // bank side
  result_store_if.store   port
);

  logic [CODE_W-1:0] avg_r;
  logic [CODE_W-1:0] iir_r;
  logic              skip_hold;
  logic              update;

  // a skipped slot holds only while the channel is also disabled
  assign skip_hold = port.sample_skipped && !port.measure_en;
  assign update    = port.sample_load && !skip_hold;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      avg_r <= cell_result_pkg::CODE_RESET;
      iir_r <= cell_result_pkg::CODE_RESET;
    end
    else if (update)
    begin
      // codes arrive already scaled, full scale is a 5 V input
      avg_r <= port.avg_code;
      iir_r <= port.iir_code;
    end
  end

  assign port.code_out = port.filt_sel ? iir_r : avg_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_skip_keeps_value: assert property (
    port.sample_load && port.sample_skipped && !port.measure_en |=> $stable(avg_r) && $stable(iir_r))
    else $error("skipped disabled channel changed its stored result");

  a_skip_needs_both: assert property (
    port.sample_load && port.sample_skipped && port.measure_en
      |=> avg_r == $past(port.avg_code) && iir_r == $past(port.iir_code))
    else $error("enabled channel did not take its sample");

endmodule // chan_result_store
`default_nettype wire

// ==== cell_voltage_result_regs.sv ====
// Purpose: read-only result registers for cell channels 3 to 7, with scan control
// Assumes: conversion engine on the same clock reports one channel slot per cycle
// Notes:   read data appear one cycle after the read strobe and only then
//
// Notes on behaviour
// - Each result register shows its channel's 14-bit code in bits 15 down to 2.
// - The code is linear with its full-scale value meaning a 5 V differential input.
// - A disabled channel skipped in the latest scan keeps its stored result.
// - Readback comes from the averaging path or the IIR path as the select bit says.
// - Result registers are read only and always show the latest stored result.
// - The hold applies only when the channel is disabled and also skipped.
`timescale 1ns/10ps
`default_nettype none
module cell_voltage_result_regs #(
  parameter int NUM_CH = cell_result_pkg::NUM_CH,
  parameter int CODE_W = cell_result_pkg::CODE_W
) (
  // clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  reset_n,
  // register port
  input  wire logic [cell_result_pkg::ADDR_W-1:0]    addr,
  input  wire logic [cell_result_pkg::DATA_W-1:0]    wdata,
  input  wire logic                                  wr_strobe,
  input  wire logic                                  rd_strobe,
  output logic      [cell_result_pkg::DATA_W-1:0]    rdata,
  output logic                                       rdata_valid,
  // conversion engine results
  input  wire logic                                  sample_valid,
  input  wire logic [cell_result_pkg::CH_IDX_W-1:0]  sample_channel,
  input  wire logic                                  sample_skipped,
  input  wire logic [CODE_W-1:0]                     sample_avg,
  input  wire logic [CODE_W-1:0]                     sample_iir,
  // control state seen by the engine
  output logic      [NUM_CH-1:0]                     channel_measure_enable,
  output logic                                       filtered_readback_select
);

  localparam int DW = cell_result_pkg::DATA_W;
  localparam int LSB = cell_result_pkg::CODE_LSB;
  localparam int IW  = cell_result_pkg::CH_IDX_W;

  // control register
  logic [NUM_CH-1:0] enable_r;
  logic [NUM_CH-1:0] enable_nxt;
  logic              select_r;
  logic              select_nxt;

  // read path
  logic [DW-1:0]     rdata_r;
  logic [DW-1:0]     rdata_nxt;
  logic              rdata_valid_r;

  // decode
  logic [NUM_CH-1:0] chan_hit;
  logic [NUM_CH-1:0] chan_load;
  logic              result_hit;
  logic              ctrl_hit;
  logic              ctrl_write;
  logic [DW-1:0]     ctrl_view;
  logic [DW-1:0]     result_view;
  logic [CODE_W-1:0] code_bus [NUM_CH];
  logic [DW-1:0]     masked_view [NUM_CH];

  // per-channel stores
  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++)
    begin : g_chan
      result_store_if #(.CODE_W(CODE_W)) store_if ();

      assign chan_hit[i]  = (addr == cell_result_pkg::RESULT_OFFSET[i]);
      assign chan_load[i] = sample_valid && (sample_channel == IW'(i));

      assign store_if.sample_load    = chan_load[i];
      assign store_if.sample_skipped = sample_skipped;
      assign store_if.measure_en     = enable_r[i];
      assign store_if.avg_code       = sample_avg;
      assign store_if.iir_code       = sample_iir;
      assign store_if.filt_sel       = select_r;
      assign code_bus[i]             = store_if.code_out;

      // left-justified code, unused low bits tied to zero
      assign masked_view[i] = chan_hit[i] ? {code_bus[i], cell_result_pkg::UNUSED_LOW_BITS} : '0;

      chan_result_store #(
        .CODE_W (CODE_W)
      ) u_store (
        .clk     (clk),
        .reset_n (reset_n),
        .port    (store_if)
      );
    end
  endgenerate

  // offsets are distinct, so at most one masked view is non-zero
  always_comb
  begin
    result_view = '0;
    for (int k = 0; k < NUM_CH; k++)
    begin
      result_view = result_view | masked_view[k];
    end
  end

  assign result_hit = |chan_hit;
  assign ctrl_hit   = (addr == cell_result_pkg::CTRL_OFFSET);
  // a write aimed at a result register decodes to nothing
  assign ctrl_write = wr_strobe && ctrl_hit;

  always_comb
  begin
    ctrl_view = '0;
    ctrl_view[cell_result_pkg::CTRL_EN_LSB +: NUM_CH] = enable_r;
    ctrl_view[cell_result_pkg::CTRL_SEL_BIT] = select_r;
  end

  assign enable_nxt = ctrl_write ? wdata[cell_result_pkg::CTRL_EN_LSB +: NUM_CH] : enable_r;
  assign select_nxt = ctrl_write ? wdata[cell_result_pkg::CTRL_SEL_BIT] : select_r;

  // read data live one cycle only; idle cycles show zero
  always_comb
  begin
    rdata_nxt = '0;
    if (!rd_strobe)
    begin
      rdata_nxt = '0;
    end
    else if (result_hit)
    begin
      rdata_nxt = result_view;
    end
    else if (ctrl_hit)
    begin
      rdata_nxt = ctrl_view;
    end
    else
    begin
      rdata_nxt = '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enable_r <= cell_result_pkg::ENABLE_RESET;
      select_r <= cell_result_pkg::SELECT_RESET;
    end
    else
    begin
      enable_r <= enable_nxt;
      select_r <= select_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_r       <= cell_result_pkg::RESULT_RESET;
      rdata_valid_r <= 1'b0;
    end
    else
    begin
      rdata_r       <= rdata_nxt;
      rdata_valid_r <= rd_strobe;
    end
  end

  assign rdata                    = rdata_r;
  assign rdata_valid              = rdata_valid_r;
  assign channel_measure_enable   = enable_r;
  assign filtered_readback_select = select_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic [DW-1:0] code_view_ch3;
  assign code_view_ch3 = {code_bus[0], cell_result_pkg::UNUSED_LOW_BITS};

  sequence s_read_ch3;
    rd_strobe && (addr == cell_result_pkg::CH3_OFFSET);
  endsequence

  sequence s_quiet_read_ch3;
    s_read_ch3 and (!sample_valid && !wr_strobe);
  endsequence

  sequence s_fresh_sample_ch3;
    sample_valid && (sample_channel == 3'h0) && !sample_skipped && !wr_strobe;
  endsequence

  a_result_field: assert property (
    s_read_ch3 |=> rdata_r == $past(code_view_ch3))
    else $error("channel 3 read did not return its code in bits 15:2");

  a_low_bits_zero: assert property (
    rd_strobe && result_hit |=> rdata_r[LSB-1:0] == 2'h0 && rdata_valid_r)
    else $error("result read showed non-zero low bits");

  a_write_ignored: assert property (
    wr_strobe && result_hit && !sample_valid |=> $stable(code_bus[0]) && $stable(select_r) && $stable(enable_r))
    else $error("write to a result register changed state");

  a_read_single_cycle: assert property (
    !rd_strobe |=> rdata_r == '0 && !rdata_valid_r)
    else $error("read data stood outside the cycle after the strobe");

  a_fresh_avg_sample: assert property (
    s_fresh_sample_ch3 ##1 (s_quiet_read_ch3 and !select_r) |=> rdata_r[DW-1:LSB] == $past(sample_avg, 2))
    else $error("read after a sample did not show the averaged code");

  a_filter_select: assert property (
    s_fresh_sample_ch3 ##1 (s_quiet_read_ch3 and select_r) |=> rdata_r[DW-1:LSB] == $past(sample_iir, 2))
    else $error("filtered readback did not show the IIR code");

  a_reset_clear: assert property (
    $rose(reset_n) |-> rdata_r == '0 && enable_r == '0 && !select_r)
    else $error("state not cleared by reset");

  // control register checks
  a_ctrl_write_lands: assert property (
    ctrl_write |=> enable_r == $past(wdata[cell_result_pkg::CTRL_EN_LSB +: NUM_CH])
      && select_r == $past(wdata[cell_result_pkg::CTRL_SEL_BIT]))
    else $error("control write did not land");

  a_ctrl_hold: assert property (
    !ctrl_write |=> $stable(enable_r) && $stable(select_r))
    else $error("control state changed without a control write");

  a_ctrl_readback: assert property (
    rd_strobe && ctrl_hit |=> rdata_r == $past(ctrl_view) && rdata_valid_r)
    else $error("control read did not return the enables and select");

  a_unmapped_read: assert property (
    rd_strobe && !result_hit && !ctrl_hit |=> rdata_r == '0 && rdata_valid_r)
    else $error("unmapped read returned data");

  a_read_answered: assert property (
    rd_strobe |=> rdata_valid_r)
    else $error("read strobe got no answer in the next cycle");

  // per-channel checks: every register answers for its own cell only
  generate
    for (i = 0; i < NUM_CH; i++)
    begin : g_chan_chk
      sequence s_slot_load;
        chan_load[i] && !wr_strobe;
      endsequence

      sequence s_quiet_read;
        rd_strobe && chan_hit[i] && !sample_valid && !wr_strobe;
      endsequence

      sequence s_fresh_then_read;
        (s_slot_load and !sample_skipped) ##1 s_quiet_read;
      endsequence

      sequence s_enabled_skip_then_read;
        (s_slot_load and (sample_skipped && enable_r[i])) ##1 s_quiet_read;
      endsequence

      sequence s_disabled_skip_then_read;
        (s_slot_load and (sample_skipped && !enable_r[i])) ##1 s_quiet_read;
      endsequence

      a_chan_readback: assert property (
        rd_strobe && chan_hit[i] |=> rdata_r == $past({code_bus[i], cell_result_pkg::UNUSED_LOW_BITS}))
        else $error("channel read did not return its own code in bits 15:2");

      // select writes are left out: flipping the path legally changes the view
      a_own_slot_only: assert property (
        !chan_load[i] && !ctrl_write |=> $stable(code_bus[i]))
        else $error("stored code changed without a slot for its channel");

      // a read strobed right after a slot must already see the new code
      a_chan_fresh_avg: assert property (
        s_fresh_then_read ##0 !select_r |=> rdata_r[DW-1:LSB] == $past(sample_avg, 2))
        else $error("read right after a slot did not show the averaged code");

      a_chan_fresh_iir: assert property (
        s_fresh_then_read ##0 select_r |=> rdata_r[DW-1:LSB] == $past(sample_iir, 2))
        else $error("read right after a slot did not show the IIR code");

      a_skip_loads_avg: assert property (
        s_enabled_skip_then_read ##0 !select_r |=> rdata_r[DW-1:LSB] == $past(sample_avg, 2))
        else $error("skipped slot of an enabled channel was not loaded");

      a_skip_loads_iir: assert property (
        s_enabled_skip_then_read ##0 select_r |=> rdata_r[DW-1:LSB] == $past(sample_iir, 2))
        else $error("skipped slot of an enabled channel lost its IIR code");

      // the held code is read through the same select, so it matches the view before the slot
      a_skip_holds_code: assert property (
        s_disabled_skip_then_read |=> rdata_r[DW-1:LSB] == $past(code_bus[i], 2))
        else $error("skipped slot of a disabled channel changed its readback");
    end
  endgenerate

endmodule // cell_voltage_result_regs
`default_nettype wire

// ==== testbench.sv ====
// Purpose: self-checking bench for the cell-voltage result register bank
// Assumes: register port answers a read in the cycle after the strobe
// Notes:   the bench model keeps both code paths of every channel
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk;
  logic        reset_n;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr_strobe;
  logic        rd_strobe;
  logic [15:0] rdata;
  logic        rdata_valid;
  logic        sample_valid;
  logic [2:0]  sample_channel;
  logic        sample_skipped;
  logic [13:0] sample_avg;
  logic [13:0] sample_iir;
  logic [4:0]  channel_measure_enable;
  logic        filtered_readback_select;
  int          num_errors;
  int          num_checks;
  int          m_avg [5];
  int          m_iir [5];
  int          m_en;
  int          m_sel;
  logic [31:0] seed;
  logic [31:0] r;

  cell_voltage_result_regs uut (
    .clk                      (clk),
    .reset_n                  (reset_n),
    .addr                     (addr),
    .wdata                    (wdata),
    .wr_strobe                (wr_strobe),
    .rd_strobe                (rd_strobe),
    .rdata                    (rdata),
    .rdata_valid              (rdata_valid),
    .sample_valid             (sample_valid),
    .sample_channel           (sample_channel),
    .sample_skipped           (sample_skipped),
    .sample_avg               (sample_avg),
    .sample_iir               (sample_iir),
    .channel_measure_enable   (channel_measure_enable),
    .filtered_readback_select (filtered_readback_select)
  );

  initial clk = 1'b0;
  always #10 clk = ~clk;

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] expect_rd(input logic [7:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (a >= 8'h49 && a <= 8'h4D)
      v = {14'(m_sel ? m_iir[a - 8'h49] : m_avg[a - 8'h49]), 2'h0};
    else if (a == 8'h5C)
      v = {7'h00, 1'(m_sel), 3'h0, 5'(m_en)};
    return v;
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic [15:0] e;
    e = expect_rd(a);
    @(posedge clk);
    rd_strobe <= 1'b1;
    addr      <= a;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1;
    check("rdata", e, rdata);
    check("rdata_valid", 16'h0001, {15'h0000, rdata_valid});
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_strobe <= 1'b1;
    addr      <= a;
    wdata     <= d;
    @(posedge clk);
    wr_strobe <= 1'b0;
    if (a == 8'h5C)
    begin
      m_en  = d[4:0];
      m_sel = d[8];
    end
    #1;
    check("enable", 16'(m_en), {11'h000, channel_measure_enable});
    check("select", 16'(m_sel), {15'h0000, filtered_readback_select});
  endtask

  // a disabled channel only holds its code when its slot is also skipped
  task automatic smp(input int ch, input logic sk, input logic [13:0] av, input logic [13:0] fi);
    @(posedge clk);
    sample_valid   <= 1'b1;
    sample_channel <= 3'(ch);
    sample_skipped <= sk;
    sample_avg     <= av;
    sample_iir     <= fi;
    @(posedge clk);
    sample_valid <= 1'b0;
    if (ch < 5 && !(sk && !m_en[ch]))
    begin
      m_avg[ch] = av;
      m_iir[ch] = fi;
    end
  endtask

  // slot and read of one channel in consecutive cycles, then the idle cycle after the answer
  task automatic smp_rd(input int ch, input logic sk, input logic [13:0] av, input logic [13:0] fi);
    logic [15:0] e;
    @(posedge clk);
    sample_valid   <= 1'b1;
    sample_channel <= 3'(ch);
    sample_skipped <= sk;
    sample_avg     <= av;
    sample_iir     <= fi;
    @(posedge clk);
    sample_valid <= 1'b0;
    rd_strobe    <= 1'b1;
    addr         <= 8'h49 + 8'(ch);
    if (ch < 5 && !(sk && !m_en[ch]))
    begin
      m_avg[ch] = av;
      m_iir[ch] = fi;
    end
    e = expect_rd(8'h49 + 8'(ch));
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1;
    check("fresh rdata", e, rdata);
    @(posedge clk);
    #1;
    check("idle rdata", 16'h0000, rdata);
    check("idle rdata_valid", 16'h0000, {15'h0000, rdata_valid});
  endtask

  task automatic model_clear();
    m_en  = 0;
    m_sel = 0;
    for (int c = 0; c < 5; c++)
    begin
      m_avg[c] = 0;
      m_iir[c] = 0;
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("Error watchdog expected end seen hang");
    give_verdict();
  end

  initial
  begin
    seed = 32'h0000001D;
    {reset_n, addr, wdata, wr_strobe, rd_strobe} = '0;
    {sample_valid, sample_channel, sample_skipped, sample_avg, sample_iir} = '0;
    num_errors = 0;
    num_checks = 0;
    model_clear();
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 8'h48; a <= 8'h4E; a++) rd(8'(a));
    rd(8'h5C);
    $display("test reset values done");
    wr(8'h5C, 16'h001F);
    for (int c = 0; c < 5; c++) smp(c, 1'b0, 14'h3FFF - 14'(c), 14'(c + 1));
    for (int c = 0; c < 5; c++) rd(8'h49 + 8'(c));
    wr(8'h5C, 16'h011F);
    for (int c = 0; c < 5; c++) rd(8'h49 + 8'(c));
    $display("test code field and readback select done");
    for (int c = 0; c < 5; c++) wr(8'h49 + 8'(c), 16'hFFFF);
    for (int c = 0; c < 5; c++) rd(8'h49 + 8'(c));
    $display("test write ignore done");
    wr(8'h5C, 16'h0004);
    smp(0, 1'b1, 14'h1234, 14'h0ABC);
    rd(8'h49);
    smp(1, 1'b0, 14'h2345, 14'h0BCD);
    rd(8'h4A);
    smp(2, 1'b1, 14'h3456, 14'h0CDE);
    rd(8'h4B);
    smp(5, 1'b0, 14'h1111, 14'h2222);
    wr(8'h5C, 16'h0100);
    for (int c = 0; c < 5; c++) rd(8'h49 + 8'(c));
    $display("test skip hold done");
    for (int s = 0; s < 2; s++)
    begin
      wr(8'h5C, {7'h00, 1'(s), 8'h02});
      for (int c = 0; c < 5; c++) smp_rd(c, 1'(c % 2), 14'(xorshift()), 14'(xorshift() >> 7));
    end
    $display("test back-to-back slot and read done");
    repeat (200)
    begin
      r = xorshift();
      case (r[1:0])
        2'h0: wr(8'h5C, r[31:16]);
        2'h1: smp(int'(r[4:2]), r[5], r[19:6], r[31:18]);
        2'h2: smp_rd(int'(r[4:2]), r[5], r[19:6], r[31:18]);
        default: rd(r[3] ? 8'h5C : 8'h48 + 8'(r[6:4]));
      endcase
    end
    $display("test random traffic done");
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    model_clear();
    for (int a = 8'h48; a <= 8'h4E; a++) rd(8'(a));
    rd(8'h5C);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
